//--- src/indexed_move_push_exec.v
// execution of the pointer-relative indexed copy and literal push instructions
`timescale 1ns/1ps
`include "indexed_move_push_consts.vh"

// What this block does
// RULE1: copy addresses are frame pointer plus unsigned 7-bit source or destination offset.
// RULE2: copy reads one byte at source, writes it unchanged to destination, 000h-FFFh.
// RULE3: program never targets counter low byte or stack top bytes with the copy.
// RULE4: source on an indirect register reads as 00h, no indirect access made.
// RULE5: destination on an indirect register makes the copy a no-op, no write.
// RULE6: push writes immediate at frame pointer address, then decrements pointer by one.
// RULE7: copy is two words and two cycles; push one word one cycle; no flags changed.
module indexed_move_push_exec #(
  parameter ADDR_W = `IMP_ADDR_W
) (
  input wire clock,
  input wire rst_b,
  input wire instrValid,
  input wire [15:0] instrWord,
  output wire instrReady,
  output wire busy,
  input wire fpLoad,
  input wire [ADDR_W-1:0] fpLoadValue,
  output wire [ADDR_W-1:0] framePointer,
  output wire [ADDR_W-1:0] memAddr,
  output wire memRead,
  input wire [7:0] memReadData,
  output wire memWrite,
  output wire [7:0] memWriteData,
  input wire srcIsIndirect,
  input wire dstIsIndirect,
  output wire flagsWriteEn,
  output wire copyDone,
  output wire pushDone
);

  // sequencer states: idle, or waiting for the second copy word
  localparam [0:0] ST_IDLE = 1'h0;
  localparam [0:0] ST_COPY2 = 1'h1;

  // zero padding in front of an offset
  localparam PAD_W = ADDR_W - `IMP_OFFSET_W;

  // sequencer and pointer state
  reg state_r;
  reg state_nxt;
  reg [ADDR_W-1:0] fp_r;
  reg [ADDR_W-1:0] fp_nxt;

  // registered memory side
  reg [ADDR_W-1:0] memAddr_r;
  reg [ADDR_W-1:0] memAddr_nxt;
  reg memRead_r;
  reg memRead_nxt;
  reg memWrite_r;
  reg memWrite_nxt;
  reg [7:0] memWriteData_r;
  reg [7:0] memWriteData_nxt;

  // registered status
  reg busy_r;
  reg copyDone_r;
  reg copyDone_nxt;
  reg pushDone_r;
  reg pushDone_nxt;

  // decode of the word on the instruction port
  wire [7:0] opcodeField;
  wire [3:0] tagField;
  wire [`IMP_OFFSET_W-1:0] offsetField;
  wire [7:0] literalField;
  wire isCopy;
  wire isPush;
  wire isSecond;

  // words taken at this edge
  wire takeCopy;
  wire takePush;
  wire takeSecond;

  // address arithmetic and the byte to copy
  wire [ADDR_W-1:0] offsetAddr;
  wire [ADDR_W-1:0] fpDecremented;
  wire [7:0] copyByte;

  // fields of the instruction word
  assign opcodeField = instrWord[`IMP_COPY_OPCODE_MSB:`IMP_COPY_OPCODE_LSB];
  assign tagField = instrWord[`IMP_TAG_MSB:`IMP_TAG_LSB];
  assign offsetField = instrWord[`IMP_OFFSET_MSB:`IMP_OFFSET_LSB];
  assign literalField = instrWord[`IMP_LITERAL_MSB:`IMP_LITERAL_LSB];

  // word classes; a push word also carries the second-word tag
  assign isCopy = opcodeField == `IMP_COPY_OPCODE;
  assign isPush = opcodeField == `IMP_PUSH_OPCODE;
  assign isSecond = tagField == `IMP_SECOND_TAG;

  // a word is taken only in the state that expects it, others are dropped since instrReady is always 1
  assign takeCopy = (state_r == ST_IDLE) && instrValid && isCopy;
  assign takePush = (state_r == ST_IDLE) && instrValid && isPush;
  assign takeSecond = (state_r == ST_COPY2) && instrValid && isSecond;

  // pointer plus zero-extended offset, wraps in the data space
  assign offsetAddr = fp_r + {{PAD_W{1'h0}}, offsetField}; // see RULE1

  // pointer after a push, wraps below zero
  assign fpDecremented = fp_r - {{(ADDR_W-1){1'h0}}, 1'h1}; // see RULE6

  // indirect source reads as zero, no indirect access is made
  assign copyByte = srcIsIndirect ? `IMP_ZERO_BYTE : memReadData; // see RULE4

  // handshake and flag outputs are constant
  assign instrReady = 1'h1;
  assign flagsWriteEn = 1'h0; // status never touched (see RULE7)

  // registered values onto the ports
  assign busy = busy_r;
  assign framePointer = fp_r;
  assign memAddr = memAddr_r;
  assign memRead = memRead_r;
  assign memWrite = memWrite_r;
  assign memWriteData = memWriteData_r;
  assign copyDone = copyDone_r;
  assign pushDone = pushDone_r;

  // sequencer: a copy holds the second state until its second word
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (takeCopy) begin
          state_nxt = ST_COPY2; // first of two words (see RULE7)
        end
      end
      ST_COPY2: begin
        if (takeSecond) begin
          state_nxt = ST_IDLE; // second word ends the copy (see RULE7)
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // pointer: a push in the same cycle wins over a load
  always @* begin
    fp_nxt = fp_r;
    if (takePush) begin
      fp_nxt = fpDecremented; // post-decrement (see RULE6)
    end else if (fpLoad) begin
      fp_nxt = fpLoadValue;
    end
  end

  // memory side for the next cycle: address, strobes, write byte
  always @* begin
    memAddr_nxt = memAddr_r;
    memRead_nxt = 1'h0;
    memWrite_nxt = 1'h0;
    memWriteData_nxt = memWriteData_r;
    if (takeCopy) begin
      memAddr_nxt = offsetAddr; // source address (see RULE1)
      memRead_nxt = 1'h1; // source read strobe (see RULE2)
    end else if (takePush) begin
      memAddr_nxt = fp_r; // write at the old pointer (see RULE6)
      memWriteData_nxt = literalField;
      memWrite_nxt = 1'h1;
    end else if (takeSecond) begin
      memAddr_nxt = offsetAddr; // destination address (see RULE1)
      memWriteData_nxt = copyByte; // byte passed unchanged (see RULE2)
      memWrite_nxt = !dstIsIndirect; // indirect target is a no-op (see RULE5)
    end
  end

  // completion pulses, one cycle each, also for a no-op copy
  always @* begin
    copyDone_nxt = takeSecond;
    pushDone_nxt = takePush;
  end

  // sequencer state and busy flag
  always @(posedge clock) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      busy_r <= 1'h0;
    end else begin
      state_r <= state_nxt;
      busy_r <= state_nxt == ST_COPY2;
    end
  end

  // frame pointer
  always @(posedge clock) begin
    if (!rst_b) begin
      fp_r <= `IMP_FP_RESET;
    end else begin
      fp_r <= fp_nxt;
    end
  end

  // memory address and write byte, held until the next operation
  always @(posedge clock) begin
    if (!rst_b) begin
      memAddr_r <= `IMP_FP_RESET;
      memWriteData_r <= `IMP_ZERO_BYTE;
    end else begin
      memAddr_r <= memAddr_nxt;
      memWriteData_r <= memWriteData_nxt;
    end
  end

  // memory strobes, one-cycle pulses
  always @(posedge clock) begin
    if (!rst_b) begin
      memRead_r <= 1'h0;
      memWrite_r <= 1'h0;
    end else begin
      memRead_r <= memRead_nxt;
      memWrite_r <= memWrite_nxt;
    end
  end

  // completion pulses
  always @(posedge clock) begin
    if (!rst_b) begin
      copyDone_r <= 1'h0;
      pushDone_r <= 1'h0;
    end else begin
      copyDone_r <= copyDone_nxt;
      pushDone_r <= pushDone_nxt;
    end
  end

endmodule

//--- src/indexed_move_push_consts.vh
// constants for the indexed copy and literal push execution block
`ifndef INDEXED_MOVE_PUSH_CONSTS_VH
`define INDEXED_MOVE_PUSH_CONSTS_VH
`define IMP_ADDR_W 12
`define IMP_OFFSET_W 7
`define IMP_COPY_OPCODE 8'hEB
`define IMP_COPY_OPCODE_MSB 15
`define IMP_COPY_OPCODE_LSB 8
`define IMP_PUSH_OPCODE 8'hFA
`define IMP_SECOND_TAG 4'hF
`define IMP_TAG_MSB 15
`define IMP_TAG_LSB 12
`define IMP_OFFSET_MSB 6
`define IMP_OFFSET_LSB 0
`define IMP_LITERAL_MSB 7
`define IMP_LITERAL_LSB 0
`define IMP_ZERO_BYTE 8'h00
`define IMP_FP_RESET 12'h000
`endif

//--- verification/data_mem.sv
// data memory model on the far side of the block
`timescale 1ns/1ps
module data_mem (
  input wire clock,
  input wire [11:0] addr,
  input wire rd,
  input wire wr,
  input wire [7:0] wdata,
  output wire [7:0] rdata
);
  reg [7:0] mem [0:4095];
  // read byte holds only while the strobe is up
  assign rdata = rd ? mem[addr] : ~mem[addr];
  always @(posedge clock) if (wr) mem[addr] <= wdata;
endmodule

//--- verification/imp_chk.sv
// checker for the indexed copy and literal push block
`timescale 1ns/1ps
module imp_chk (
  input wire clock,
  input wire rst_b,
  input wire instrValid,
  input wire [15:0] instrWord,
  input wire busy,
  input wire [11:0] framePointer,
  input wire memRead,
  input wire memWrite,
  input wire dstIsIndirect,
  input wire flagsWriteEn,
  input wire copyDone,
  input wire pushDone
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // accepted words of each kind
  wire pushIn = instrValid && instrWord[15:8] == 8'hFA && !busy;
  wire copyIn = instrValid && instrWord[15:8] == 8'hEB && !busy;
  wire word2In = instrValid && instrWord[15:12] == 4'hF && busy;
  chk_push_write: assert property (pushIn |=> memWrite && pushDone)
    else $error("push did not write");
  chk_push_decr: assert property (pushIn |=> framePointer == $past(framePointer) - 12'h001)
    else $error("pointer not decremented");
  chk_copy_read: assert property (copyIn |=> memRead && busy && !memWrite)
    else $error("copy source not read");
  chk_copy_write: assert property (word2In && !dstIsIndirect |=> memWrite && copyDone)
    else $error("copy did not write");
  chk_copy_nop: assert property (word2In && dstIsIndirect |=> !memWrite && copyDone)
    else $error("indirect target written");
  chk_no_flags: assert property (!flagsWriteEn)
    else $error("flags written");
  cover property (pushDone);
  cover property (copyDone && memWrite);
  cover property (copyDone && !memWrite);
endmodule
bind indexed_move_push_exec imp_chk imp_chk_inst(.*);

//--- verification/tb_indexed_move_push_exec.sv
// testbench for the indexed copy and literal push block
`timescale 1ns/1ps
`define CHK(n,e,a) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s exp %h got %h", n, e, a); end end
module tb_indexed_move_push_exec;
  reg clock = 0, rst_b = 0, v = 0, fpl = 0, si = 0, di = 0;
  reg [15:0] w = 0;
  reg [11:0] fpv = 0;
  wire [11:0] fp, ma;
  wire mr, mw, rdy;
  wire [7:0] rd, wd;
  int n_mismatch = 0, checks = 0, cyc = 0;
  always #5 clock = ~clock;
  // hang guard
  always @(posedge clock) if (++cyc > 2000) begin n_mismatch++; wrap_up; end
  indexed_move_push_exec indexed_move_push_exec_inst(.clock(clock), .rst_b(rst_b),
    .instrValid(v), .instrWord(w), .instrReady(rdy), .busy(), .fpLoad(fpl), .fpLoadValue(fpv),
    .framePointer(fp), .memAddr(ma), .memRead(mr), .memReadData(rd), .memWrite(mw),
    .memWriteData(wd), .srcIsIndirect(si), .dstIsIndirect(di), .flagsWriteEn(),
    .copyDone(), .pushDone());
  data_mem data_mem_inst(.clock(clock), .addr(ma), .rd(mr), .wr(mw), .wdata(wd), .rdata(rd));
  task automatic step; @(posedge clock); #1; endtask
  task automatic setfp(input [11:0] f); fpl = 1; fpv = f; step; fpl = 0; endtask
  // two-word copy, then judge the target byte; d marks the target indirect
  task automatic copy(input [11:0] f, input [6:0] zs, zd, input s, d, input [7:0] e);
    setfp(f); data_mem_inst.mem[f + zs] = 8'h5A; data_mem_inst.mem[f + zd] = 8'hC3;
    v = 1; w = {8'hEB, 1'b0, zs}; step; w = {4'hF, 5'h00, zd}; si = s; di = d; step;
    v = 0; si = 0; di = 0; step;
    `CHK("copy dst", e, data_mem_inst.mem[f + zd])
  endtask
  task automatic push(input [11:0] f, input [7:0] k);
    setfp(f); v = 1; w = {8'hFA, k}; step; v = 0;
    `CHK("pointer", f - 12'h001, fp)
    `CHK("ready", 1'b1, rdy)
    step; `CHK("push byte", k, data_mem_inst.mem[f])
  endtask
  task automatic wrap_up;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clock); #1 rst_b = 1;
    copy(12'hFF0, 7'h7F, 7'h05, 0, 0, 8'h5A);
    copy(12'h080, 7'h05, 7'h06, 1, 0, 8'h00);
    copy(12'h080, 7'h05, 7'h06, 0, 1, 8'hC3);
    push(12'h000, 8'hA5);
    push(12'h1EC, 8'h08);
    wrap_up;
  end
endmodule
